// File: wd_pkg.sv
// Shared constants and types of the windowed watchdog
package wd_pkg;

   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register map (word index equals address on the plain port)
   localparam logic [ADDR_W-1:0] A_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] A_CLKCFG   = 4'h1;
   localparam logic [ADDR_W-1:0] A_ARM      = 4'h2;
   localparam logic [ADDR_W-1:0] A_STATUS   = 4'h3;
   localparam logic [ADDR_W-1:0] A_MASK     = 4'h4;
   localparam logic [ADDR_W-1:0] A_COUNT_LO = 4'h5;
   localparam logic [ADDR_W-1:0] A_COUNT_HI = 4'h6;
   localparam logic [ADDR_W-1:0] A_STATE    = 4'h7;

   // Control register fields
   localparam int RATE_W       = 3;
   localparam int CTRL_RATE_LSB = 0;
   localparam int CTRL_WMASK   = 5;
   localparam int CTRL_WINDOW  = 6;
   localparam logic [RATE_W-1:0] RATE_OFF = 3'h0;

   // Clock configuration register fields
   localparam int CFG_W        = 6;
   localparam int CFG_SEL_LOW  = 0;
   localparam int CFG_SEL_HIGH = 1;
   localparam int CFG_HOLD     = 2;
   localparam int CFG_PSEUDO_STOP_ENABLE     = 3;
   localparam int CFG_PCE      = 4;
   localparam int CFG_OSCILLATOR_ENABLE     = 5;
   localparam logic [CFG_W-1:0] CFG_RST = 6'h00;

   // Event bits shared by status and mask
   localparam int EV_W       = 3;
   localparam int EV_TIMEOUT = 0;
   localparam int EV_BADVAL  = 1;
   localparam int EV_EARLY   = 2;
   localparam logic [EV_W-1:0] EV_RST = 3'h0;

   // State register fields
   localparam int SS_LOCKED  = 0;
   localparam int SS_BUSY    = 1;
   localparam int SS_VECTOR  = 2;
   localparam int SS_PRELOAD = 3;
   localparam int SS_HALF    = 4;

   // Service values
   localparam logic [DATA_W-1:0] ARM_FIRST  = 8'h55;
   localparam logic [DATA_W-1:0] ARM_SECOND = 8'haa;

   // Watchdog counter
   localparam int CNT_W = 16;
   localparam int PER_W = CNT_W + 1;
   typedef logic [CNT_W-1:0] cnt_t;
   typedef logic [PER_W-1:0] per_t;

   // Reset generator timing in clock cycles
   localparam int RG_CNT_W         = 10;
   localparam int RST_DRIVE_CYCLES = 512;
   localparam int RST_WAIT_CYCLES  = 256;
   localparam logic [RG_CNT_W-1:0] RST_DRIVE_LAST = RG_CNT_W'(RST_DRIVE_CYCLES - 1);
   localparam logic [RG_CNT_W-1:0] RST_WAIT_LAST  = RG_CNT_W'(RST_WAIT_CYCLES - 1);

   typedef enum logic [1:0] {
      RG_IDLE,
      RG_DRIVE,
      RG_WAIT
   } rg_state_t;

endpackage

// File: wd_sync_if.sv
// Synchronised level and rising-edge pulse of one asynchronous input
`timescale 1ns/1ps
interface wd_sync_if;
   logic level;
   logic rise;
   modport src (output level, output rise);
   modport dst (input level, input rise);
endinterface

// File: wd_sync.sv
// Two-flop synchroniser with rising-edge detector
`timescale 1ns/1ps
module wd_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic   mclk_i,
   input  wire logic   arst_n_i,
   input  wire logic   async_i,
   wd_sync_if.src      sync_o
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   // First flop feeds only the second; edge taken on clean copies
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
         prev_r <= RST_VAL;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // Level and one-cycle edge pulse
   assign sync_o.level = sync_r;
   assign sync_o.rise  = sync_r & ~prev_r;

endmodule

// File: windowed_watchdog_timer.sv
// Windowed watchdog with service sequence, preload, write-once lock and reset generator
`timescale 1ns/1ps
module windowed_watchdog_timer #(
   parameter int             BASE_EXP        = 7,
   parameter logic [3:0]     WAKE_SYNC_TICKS = 4'h2
) (
   input  wire logic                        mclk_i,
   input  wire logic                        arst_n_i,
   input  wire logic [wd_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [wd_pkg::DATA_W-1:0]   wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [wd_pkg::DATA_W-1:0]   rdata_o,
   output logic                             irq_o,
   input  wire logic                        autonomous_rc_clock_i,
   input  wire logic                        internal_rc_clock_i,
   input  wire logic                        crystal_osc_clock_i,
   input  wire logic                        oscillator_up_i,
   input  wire logic                        stop_mode_i,
   input  wire logic                        normal_mode_i,
   input  wire logic                        nvm_valid_i,
   input  wire logic [wd_pkg::RATE_W-1:0]   nvm_rate_i,
   input  wire logic                        nvm_window_i,
   input  wire logic                        osc_fail_pending_i,
   input  wire logic                        rst_pin_i,
   output logic                             rst_pin_o,
   output logic                             rst_pin_oe_o,
   output logic                             sys_reset_o,
   output logic                             wd_vector_o
);

   // Synchronised views of the foreign-domain inputs
   wd_sync_if aclk_s ();
   wd_sync_if irc_s ();
   wd_sync_if osc_s ();
   wd_sync_if oscup_s ();
   wd_sync_if pin_s ();

   // Source clocks must stay below half the system rate to be seen
   wd_sync #(.RST_VAL(1'b0)) u_aclk (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .async_i  (autonomous_rc_clock_i),
      .sync_o   (aclk_s)
   );
   wd_sync #(.RST_VAL(1'b0)) u_irc (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .async_i  (internal_rc_clock_i),
      .sync_o   (irc_s)
   );
   wd_sync #(.RST_VAL(1'b0)) u_osc (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .async_i  (crystal_osc_clock_i),
      .sync_o   (osc_s)
   );
   wd_sync #(.RST_VAL(1'b0)) u_oscup (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .async_i  (oscillator_up_i),
      .sync_o   (oscup_s)
   );
   // Pin idles high through its pull-up
   wd_sync #(.RST_VAL(1'b1)) u_pin (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .async_i  (rst_pin_i),
      .sync_o   (pin_s)
   );

   // Configuration and state
   logic [wd_pkg::RATE_W-1:0] rate_r;
   logic                      window_r;
   logic                      locked_r;
   logic                      preload_pend_r;
   logic                      preload_on_r;
   logic [wd_pkg::CFG_W-1:0]  cfg_r;
   logic [wd_pkg::EV_W-1:0]   status_r;
   logic [wd_pkg::EV_W-1:0]   mask_r;
   wd_pkg::cnt_t              cnt_r;
   logic                      half_r;
   logic                      stop_prev_r;
   logic [3:0]                wake_cnt_r;
   logic                      cause_pend_r;
   wd_pkg::rg_state_t         rg_state_r;
   wd_pkg::rg_state_t         rg_state_nxt;
   logic [wd_pkg::RG_CNT_W-1:0] rg_cnt_r;
   logic [wd_pkg::RG_CNT_W-1:0] rg_cnt_nxt;
   logic [wd_pkg::DATA_W-1:0] rdata_r;
   logic                      irq_r;
   logic                      pin_oe_r;
   logic                      sys_reset_r;
   logic                      vector_r;

   // Decoded strobes
   logic ctrl_wr;
   logic cfg_wr;
   logic arm_wr;
   logic status_wr;
   logic mask_wr;

   assign ctrl_wr   = wr_i && (addr_i == wd_pkg::A_CTRL) && !preload_pend_r;
   assign cfg_wr    = wr_i && (addr_i == wd_pkg::A_CLKCFG);
   assign arm_wr    = wr_i && (addr_i == wd_pkg::A_ARM);
   assign status_wr = wr_i && (addr_i == wd_pkg::A_STATUS);
   assign mask_wr   = wr_i && (addr_i == wd_pkg::A_MASK);

   // Clock source choice and stop-mode behaviour
   logic sel_low;
   logic sel_high;
   logic tick;
   logic stop_run;
   logic enabled;
   logic rg_idle;
   logic count_en;

   assign sel_low  = cfg_r[wd_pkg::CFG_SEL_LOW];
   assign sel_high = cfg_r[wd_pkg::CFG_SEL_HIGH];
   assign tick     = sel_high ? aclk_s.rise :
                     (sel_low ? osc_s.rise : irc_s.rise);
   assign stop_run = sel_high ? !cfg_r[wd_pkg::CFG_HOLD] :
                     (cfg_r[wd_pkg::CFG_PSEUDO_STOP_ENABLE] && cfg_r[wd_pkg::CFG_PCE] && sel_low
                      && cfg_r[wd_pkg::CFG_OSCILLATOR_ENABLE] && oscup_s.level);
   assign enabled  = (rate_r != wd_pkg::RATE_OFF);
   assign rg_idle  = (rg_state_r == wd_pkg::RG_IDLE);
   assign count_en = enabled && tick && (!stop_mode_i || stop_run)
                     && (wake_cnt_r == 4'h0) && rg_idle
                     && !(stop_prev_r && sel_high && cfg_r[wd_pkg::CFG_HOLD]);

   // Period of the selected rate in counter ticks, doubling per code
   wd_pkg::per_t period;
   wd_pkg::cnt_t last_cnt;
   wd_pkg::cnt_t open_at;

   assign period   = wd_pkg::per_t'(1) << (BASE_EXP + int'(rate_r));
   assign last_cnt = wd_pkg::CNT_W'(period - wd_pkg::per_t'(1));
   assign open_at  = wd_pkg::CNT_W'(period - (period >> 2));

   // Service sequence checks
   logic svc_wr;
   logic bad_val;
   logic early;
   logic svc_first;
   logic svc_done;
   logic timeout;
   logic wd_event;

   assign svc_wr    = arm_wr && enabled && rg_idle;
   assign bad_val   = svc_wr && (wdata_i != wd_pkg::ARM_FIRST)
                      && (wdata_i != wd_pkg::ARM_SECOND);
   assign early     = svc_wr && !bad_val && window_r && (cnt_r < open_at);
   assign svc_first = svc_wr && !early && (wdata_i == wd_pkg::ARM_FIRST);
   assign svc_done  = svc_wr && !early && half_r
                      && (wdata_i == wd_pkg::ARM_SECOND);
   assign timeout   = count_en && (cnt_r == last_cnt);
   assign wd_event  = bad_val || early || timeout;

   // Preload at release, then one effective software write in normal mode
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         preload_pend_r <= 1'b1;
         preload_on_r   <= 1'b0;
         rate_r         <= wd_pkg::RATE_OFF;
         window_r       <= 1'b0;
         locked_r       <= 1'b0;
      end else if (preload_pend_r) begin
         preload_pend_r <= 1'b0;
         if (normal_mode_i && nvm_valid_i) begin
            rate_r       <= nvm_rate_i;
            window_r     <= nvm_window_i;
            preload_on_r <= (nvm_rate_i != wd_pkg::RATE_OFF);
         end
      end else if (ctrl_wr && !wdata_i[wd_pkg::CTRL_WMASK]) begin
         if (!normal_mode_i) begin
            // Special mode keeps the register freely writable
            rate_r   <= wdata_i[wd_pkg::CTRL_RATE_LSB +: wd_pkg::RATE_W];
            window_r <= wdata_i[wd_pkg::CTRL_WINDOW];
         end else if (!locked_r) begin
            locked_r <= 1'b1;
            window_r <= wdata_i[wd_pkg::CTRL_WINDOW];
            if (!(preload_on_r && (wdata_i[wd_pkg::CTRL_RATE_LSB +: wd_pkg::RATE_W]
                                   == wd_pkg::RATE_OFF))) begin
               rate_r <= wdata_i[wd_pkg::CTRL_RATE_LSB +: wd_pkg::RATE_W];
            end
         end
      end
   end

   // Clock configuration, reset to the internal RC source
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_r <= wd_pkg::CFG_RST;
      end else if (cfg_wr && !(normal_mode_i && locked_r)) begin
         cfg_r <= wdata_i[wd_pkg::CFG_W-1:0];
      end
   end

   // Half-sequence flag: set by the first byte, spent by the second
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         half_r <= 1'b0;
      end else if (wd_event || svc_done || !enabled) begin
         half_r <= 1'b0;
      end else if (svc_first) begin
         half_r <= 1'b1;
      end
   end

   // Watchdog counter; cleared on service, on any reset cause and while off
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= '0;
      end else if (wd_event || svc_done || !enabled) begin
         cnt_r <= '0;
      end else if (count_en) begin
         cnt_r <= cnt_r + wd_pkg::cnt_t'(1);
      end
   end

   // Wake latency: hold-set autonomous source resyncs after stop exit
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stop_prev_r <= 1'b0;
         wake_cnt_r  <= 4'h0;
      end else begin
         stop_prev_r <= stop_mode_i;
         if (stop_prev_r && !stop_mode_i && sel_high && cfg_r[wd_pkg::CFG_HOLD]) begin
            wake_cnt_r <= WAKE_SYNC_TICKS;
         end else if ((wake_cnt_r != 4'h0) && aclk_s.rise) begin
            wake_cnt_r <= wake_cnt_r - 4'h1;
         end
      end
   end

   // Reset generator sequencing
   always_comb begin
      rg_state_nxt = rg_state_r;
      rg_cnt_nxt   = rg_cnt_r;
      case (rg_state_r)
         wd_pkg::RG_IDLE: begin
            if (wd_event) begin
               rg_state_nxt = wd_pkg::RG_DRIVE;
               rg_cnt_nxt   = '0;
            end
         end
         wd_pkg::RG_DRIVE: begin
            if (rg_cnt_r == wd_pkg::RST_DRIVE_LAST) begin
               rg_state_nxt = wd_pkg::RG_WAIT;
               rg_cnt_nxt   = '0;
            end else begin
               rg_cnt_nxt = rg_cnt_r + wd_pkg::RG_CNT_W'(1);
            end
         end
         wd_pkg::RG_WAIT: begin
            if (rg_cnt_r == wd_pkg::RST_WAIT_LAST) begin
               rg_state_nxt = wd_pkg::RG_IDLE;
               rg_cnt_nxt   = '0;
            end else begin
               rg_cnt_nxt = rg_cnt_r + wd_pkg::RG_CNT_W'(1);
            end
         end
         default: begin
            rg_state_nxt = wd_pkg::RG_IDLE;
            rg_cnt_nxt   = '0;
         end
      endcase
   end

   // Sequencer flops and pin drive; pin is open drain, low when enabled
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rg_state_r  <= wd_pkg::RG_IDLE;
         rg_cnt_r    <= '0;
         pin_oe_r    <= 1'b0;
         sys_reset_r <= 1'b0;
      end else begin
         rg_state_r  <= rg_state_nxt;
         rg_cnt_r    <= rg_cnt_nxt;
         pin_oe_r    <= (rg_state_nxt == wd_pkg::RG_DRIVE);
         sys_reset_r <= (rg_state_nxt != wd_pkg::RG_IDLE);
      end
   end

   // Cause pending and vector choice at the sampling point
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cause_pend_r <= 1'b0;
         vector_r     <= 1'b0;
      end else if (rg_idle && wd_event) begin
         cause_pend_r <= 1'b1;
         vector_r     <= 1'b0;
      end else if ((rg_state_r == wd_pkg::RG_WAIT) && (rg_cnt_r == wd_pkg::RST_WAIT_LAST)) begin
         vector_r     <= pin_s.level && !osc_fail_pending_i && cause_pend_r;
         cause_pend_r <= 1'b0;
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         status_r <= wd_pkg::EV_RST;
      end else begin
         status_r <= (status_r & ~(status_wr ? wdata_i[wd_pkg::EV_W-1:0] : wd_pkg::EV_RST))
                     | {early, bad_val, timeout};
      end
   end

   // Mask register
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mask_r <= wd_pkg::EV_RST;
      end else if (mask_wr) begin
         mask_r <= wdata_i[wd_pkg::EV_W-1:0];
      end
   end

   // Interrupt level, one cycle behind the status bits
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_r & mask_r);
      end
   end

   // Read port: data stand only in the cycle after the strobe
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r <= '0;
      end else if (!rd_i) begin
         rdata_r <= '0;
      end else if (addr_i == wd_pkg::A_CTRL) begin
         rdata_r <= '0;
         rdata_r[wd_pkg::CTRL_RATE_LSB +: wd_pkg::RATE_W] <= rate_r;
         rdata_r[wd_pkg::CTRL_WINDOW]                       <= window_r;
      end else if (addr_i == wd_pkg::A_CLKCFG) begin
         rdata_r <= wd_pkg::DATA_W'(cfg_r);
      end else if (addr_i == wd_pkg::A_STATUS) begin
         rdata_r <= wd_pkg::DATA_W'(status_r);
      end else if (addr_i == wd_pkg::A_MASK) begin
         rdata_r <= wd_pkg::DATA_W'(mask_r);
      end else if (addr_i == wd_pkg::A_COUNT_LO) begin
         rdata_r <= cnt_r[wd_pkg::DATA_W-1:0];
      end else if (addr_i == wd_pkg::A_COUNT_HI) begin
         rdata_r <= cnt_r[wd_pkg::CNT_W-1:wd_pkg::DATA_W];
      end else if (addr_i == wd_pkg::A_STATE) begin
         rdata_r <= '0;
         rdata_r[wd_pkg::SS_LOCKED]  <= locked_r;
         rdata_r[wd_pkg::SS_BUSY]    <= !rg_idle;
         rdata_r[wd_pkg::SS_VECTOR]  <= vector_r;
         rdata_r[wd_pkg::SS_PRELOAD] <= preload_on_r;
         rdata_r[wd_pkg::SS_HALF]    <= half_r;
      end else begin
         rdata_r <= '0;                                                        // Arm and unmapped read zero
      end
   end

   // Outputs straight from flops; pin data is a constant low
   assign rdata_o      = rdata_r;
   assign irq_o        = irq_r;
   assign rst_pin_o    = 1'b0;
   assign rst_pin_oe_o = pin_oe_r;
   assign sys_reset_o  = sys_reset_r;
   assign wd_vector_o  = vector_r;

endmodule

// File: wd_port_properties.sv
// Port checker of the windowed watchdog timer and its bind
`timescale 1ns/1ps
module wd_port_properties (
   input wire logic                      mclk_i,
   input wire logic                      arst_n_i,
   input wire logic [wd_pkg::ADDR_W-1:0] addr_i,
   input wire logic [wd_pkg::DATA_W-1:0] wdata_i,
   input wire logic                      wr_i,
   input wire logic                      rd_i,
   input wire logic [wd_pkg::DATA_W-1:0] rdata_o,
   input wire logic                      irq_o,
   input wire logic                      rst_pin_o,
   input wire logic                      rst_pin_oe_o,
   input wire logic                      sys_reset_o,
   input wire logic                      wd_vector_o
);
   logic [9:0] oe_cnt_r;
   logic [8:0] wt_cnt_r;
   logic [2:0] mask_r;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   // Run lengths of the drive and wait phases, cleared whenever a phase is left
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         oe_cnt_r <= 10'h000;
         wt_cnt_r <= 9'h000;
      end else begin
         oe_cnt_r <= rst_pin_oe_o ? oe_cnt_r + 10'h001 : 10'h000;
         wt_cnt_r <= (sys_reset_o && !rst_pin_oe_o) ? wt_cnt_r + 9'h001 : 9'h000;
      end
   end

   // Shadow of the mask, so a quiet interrupt can be judged from the port alone
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mask_r <= 3'h0;
      end else if (wr_i && addr_i == wd_pkg::A_MASK) begin
         mask_r <= wdata_i[2:0];
      end
   end

   a_pin_data_low: assert property (rst_pin_o == 1'b0)
      else $error("reset pin data not low");
   a_drive_len: assert property ($fell(rst_pin_oe_o) |-> oe_cnt_r == 10'h200)
      else $error("pin drive phase not 512 cycles");
   a_wait_len: assert property ($fell(sys_reset_o) |-> wt_cnt_r == 9'h100)
      else $error("wait phase not 256 cycles");
   a_drive_starts_seq: assert property ($rose(rst_pin_oe_o) |-> $rose(sys_reset_o))
      else $error("pin drive began outside a new sequence");
   a_drive_in_seq: assert property (rst_pin_oe_o |-> sys_reset_o)
      else $error("pin driven without system reset");
   a_vector_cleared: assert property ($rose(sys_reset_o) |-> !wd_vector_o)
      else $error("vector kept into new sequence");
   a_vector_at_end: assert property ($rose(wd_vector_o) |-> $fell(sys_reset_o))
      else $error("vector chosen away from sequence end");
   a_irq_masked_off: assert property ($past(mask_r) == 3'h0 |-> !irq_o)
      else $error("interrupt with all events masked");
   a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read answer cycle");

   c_sequence_done: cover property ($fell(sys_reset_o));
   c_irq_raised: cover property ($rose(irq_o));
   c_read_answer: cover property (rd_i ##1 rdata_o != 8'h00);
endmodule

bind windowed_watchdog_timer wd_port_properties i_props (
   .mclk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
   .rst_pin_o, .rst_pin_oe_o, .sys_reset_o, .wd_vector_o
);

// File: windowed_watchdog_timer_tb.sv
// Self-checking bench of the windowed watchdog timer
`timescale 1ns/1ps
module windowed_watchdog_timer_tb;
   logic                      mclk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [wd_pkg::ADDR_W-1:0] addr_i = 4'h0;
   logic [wd_pkg::DATA_W-1:0] wdata_i = 8'h00, rdata_o, rv;
   logic                      autonomous_rc_clock_i = 1'b0, internal_rc_clock_i = 1'b0;
   logic                      crystal_osc_clock_i = 1'b0, oscillator_up_i = 1'b1;
   logic                      stop_mode_i = 1'b0, normal_mode_i = 1'b1, nvm_valid_i = 1'b0;
   logic [wd_pkg::RATE_W-1:0] nvm_rate_i = 3'h0;
   logic                      nvm_window_i = 1'b0, osc_fail_pending_i = 1'b0, rd_seen = 1'b0;
   logic                      irq_o, rst_pin_i, rst_pin_o, rst_pin_oe_o, sys_reset_o, wd_vector_o;
   logic [8:0]                exp_q[$];
   logic [8:0]                note;
   logic [31:0]               seed = 32'h00013534;
   int                        err_count = 0, cmp_count = 0;

   // Open-drain pin with pull-up
   assign rst_pin_i = rst_pin_oe_o ? 1'b0 : 1'b1;

   initial begin
      forever #25 mclk_i = ~mclk_i;
   end
   // Counter sources well below half the system clock
   always #110 autonomous_rc_clock_i = ~autonomous_rc_clock_i;
   always #100 internal_rc_clock_i = ~internal_rc_clock_i;
   always #150 crystal_osc_clock_i = ~crystal_osc_clock_i;

   windowed_watchdog_timer #(.BASE_EXP(2), .WAKE_SYNC_TICKS(4'h8)) i_dut (
      .mclk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
      .autonomous_rc_clock_i, .internal_rc_clock_i, .crystal_osc_clock_i, .oscillator_up_i,
      .stop_mode_i, .normal_mode_i, .nvm_valid_i, .nvm_rate_i, .nvm_window_i,
      .osc_fail_pending_i, .rst_pin_i, .rst_pin_o, .rst_pin_oe_o, .sys_reset_o, .wd_vector_o
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic cmp(input logic [7:0] e, input logic [7:0] a);
      cmp_count++;
      if (e !== a) begin
         err_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask

   // Strobe ends with a spare edge so back-to-back calls never re-drive it
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic sk);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back({sk, e});
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      rv = rdata_o;
      @(posedge mclk_i);
   endtask

   task automatic restart(input logic v, input logic [2:0] r, input logic w);
      arst_n_i <= 1'b0;
      nvm_valid_i <= v;
      nvm_rate_i <= r;
      nvm_window_i <= w;
      repeat (10) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
   endtask

   // Waits for a reset sequence, checks its cause and the chosen vector
   task automatic wait_seq(input int n, input logic [7:0] st, input logic v = 1'b1);
      while (sys_reset_o !== 1'b1 && n > 0) begin
         @(posedge mclk_i);
         n--;
      end
      cmp(8'h01, {7'h00, sys_reset_o});
      rd(wd_pkg::A_STATUS, st, 1'b0);
      repeat (780) @(posedge mclk_i);
      cmp({7'h00, v}, {7'h00, wd_vector_o});
   endtask

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Read answers are matched to the oldest note one cycle after the strobe
   always @(posedge mclk_i) begin
      if (rd_seen === 1'b1) begin
         note = exp_q.pop_front();
         if (!note[8]) cmp(note[7:0], rdata_o);
      end
      rd_seen <= rd_i;
   end

   // Guards against a hang, sized well above the planned run
   initial begin
      #2000000;
      err_count++;
      results();
   end

   initial begin
      int i;
      int j;
      int n;
      int p;
      logic [7:0] b;
      // Preload, masked write, one-time lock, map, timeout and interrupt
      restart(1'b1, 3'h5, 1'b1);
      rd(wd_pkg::A_CTRL, 8'h45, 1'b0);
      rd(wd_pkg::A_CLKCFG, 8'h00, 1'b0);
      wr(wd_pkg::A_CTRL, 8'h22);
      rd(wd_pkg::A_CTRL, 8'h45, 1'b0);
      rd(wd_pkg::A_STATE, 8'h08, 1'b0);
      wr(wd_pkg::A_CTRL, 8'h00);
      wr(wd_pkg::A_CTRL, 8'h03);
      wr(wd_pkg::A_CLKCFG, 8'h01);
      rd(wd_pkg::A_CTRL, 8'h05, 1'b0);
      rd(wd_pkg::A_STATE, 8'h09, 1'b0);
      rd(wd_pkg::A_CLKCFG, 8'h00, 1'b0);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00, 1'b0);
      rd(wd_pkg::A_ARM, 8'h00, 1'b0);
      wr(wd_pkg::A_MASK, 8'h07);
      wait_seq(1200, 8'h01);
      cmp(8'h01, {7'h00, irq_o});
      wr(wd_pkg::A_STATUS, 8'h07);
      rd(wd_pkg::A_STATUS, 8'h00, 1'b0);
      cmp(8'h00, {7'h00, irq_o});
      $display("preload and lock test done");
      // Every rate code against its period, code zero staying off
      for (i = 0; i < 8; i++) begin
         restart(1'b1, i[2:0], 1'b0);
         n = 0;
         while (sys_reset_o !== 1'b1 && n < 2100) begin
            @(posedge mclk_i);
            n++;
         end
         p = (i == 0) ? 2100 : 4 << (2 + i);
         cmp(8'h01, {7'h00, n >= p - 12 && n <= p + 8});
      end
      $display("rate test done");
      // Autonomous source serviced, then keeps running in stop mode until timeout
      restart(1'b0, 3'h0, 1'b0);
      wr(wd_pkg::A_CLKCFG, 8'h02);
      rd(wd_pkg::A_CLKCFG, 8'h02, 1'b0);
      wr(wd_pkg::A_CTRL, 8'h02);
      for (i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         repeat (20 + seed[4:0]) @(posedge mclk_i);
         wr(wd_pkg::A_ARM, 8'h55);
         wr(wd_pkg::A_ARM, 8'haa);
      end
      rd(wd_pkg::A_STATUS, 8'h00, 1'b0);
      stop_mode_i <= 1'b1;
      wait_seq(300, 8'h01);
      stop_mode_i <= 1'b0;
      $display("service and stop run test done");
      // Internal source holds in stop mode, then a random bad arm value
      restart(1'b0, 3'h0, 1'b0);
      wr(wd_pkg::A_CTRL, 8'h01);
      stop_mode_i <= 1'b1;
      repeat (300) @(posedge mclk_i);
      rd(wd_pkg::A_STATUS, 8'h00, 1'b0);
      stop_mode_i <= 1'b0;
      wait_seq(100, 8'h01);
      wr(wd_pkg::A_STATUS, 8'h07);
      seed = lfsr(seed);
      b = (seed[7:0] == 8'h55 || seed[7:0] == 8'haa) ? 8'h12 : seed[7:0];
      wr(wd_pkg::A_ARM, b);
      wait_seq(4, 8'h02);
      // Crystal source keeps running in stop mode with the full oscillator setup
      restart(1'b0, 3'h0, 1'b0);
      wr(wd_pkg::A_CLKCFG, 8'h39);
      wr(wd_pkg::A_CTRL, 8'h01);
      stop_mode_i <= 1'b1;
      wait_seq(200, 8'h01);
      // Held autonomous source in stop, then the wake latency after exit
      restart(1'b0, 3'h0, 1'b0);
      wr(wd_pkg::A_CLKCFG, 8'h06);
      wr(wd_pkg::A_CTRL, 8'h02);
      repeat (40) @(posedge mclk_i);
      rd(wd_pkg::A_COUNT_LO, 8'h00, 1'b0);
      stop_mode_i <= 1'b0;
      repeat (20) @(posedge mclk_i);
      rd(wd_pkg::A_COUNT_LO, 8'h00, 1'b0);
      wait_seq(150, 8'h01);
      $display("stop hold and bad value test done");
      // Window mode: service inside the last quarter, then an early write
      restart(1'b0, 3'h0, 1'b0);
      wr(wd_pkg::A_CTRL, 8'h42);
      for (i = 0; i < 3; i++) begin
         j = 0;
         do begin
            rd(wd_pkg::A_COUNT_LO, 8'h00, 1'b1);
            j++;
         end while ((rv < 8'h0c || rv > 8'h0d) && j < 40);
         wr(wd_pkg::A_ARM, 8'h55);
         wr(wd_pkg::A_ARM, 8'haa);
      end
      rd(wd_pkg::A_STATUS, 8'h00, 1'b0);
      osc_fail_pending_i <= 1'b1;
      wr(wd_pkg::A_ARM, 8'h55);
      wait_seq(4, 8'h04, 1'b0);
      $display("window test done");
      results();
   end
endmodule
